// ===== logic/host_port_pkg.sv
package host_port_pkg;
  // ==========================================================
  // APB register offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_DIR     = 8'h04;
  localparam logic [7:0] OFS_GPO     = 8'h08;
  localparam logic [7:0] OFS_GPI     = 8'h0C;
  localparam logic [7:0] OFS_RXWORD  = 8'h10;
  localparam logic [7:0] OFS_INTRX   = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_MASK    = 8'h1C;
  localparam logic [7:0] OFS_VECTOR  = 8'h20;
  // ==========================================================
  // Port control fields
  localparam int CTRL_W         = 16;
  localparam int CTRL_HOST_FN   = 0;
  localparam int CTRL_MUX       = 1;
  localparam int CTRL_AS_POL    = 2;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam int PIN_W          = 10;
  localparam logic [9:0] PIN_RST  = 10'h000;
  // ==========================================================
  // Status and interrupt bits
  localparam int ST_RX_FULL     = 0;
  localparam int ST_TX_EMPTY    = 1;
  localparam int ST_HCMD        = 2;
  localparam int ST_INTRX_VALID = 3;
  localparam int EV_INTRX       = 8;
  localparam int EV_RX_TAKEN    = 9;
  localparam int EV_HCMD        = 10;
  localparam int EV_W           = 3;
  // ==========================================================
  // Host-side byte addresses
  localparam logic [1:0] HA_STATUS = 2'h0;
  localparam logic [1:0] HA_HIGH   = 2'h1;
  localparam logic [1:0] HA_MIDDLE = 2'h2;
  localparam logic [1:0] HA_LOW    = 2'h3;
  localparam int HCMD_BIT          = 7;
  localparam int VEC_W             = 7;
endpackage : host_port_pkg

// ===== logic/host_parallel_port_pins.sv
`timescale 1ns/1ps
// Overview of operation
// R1: The receive-full flag is set while all three receive bytes hold data not yet read.
// R2: The host reads the receive bytes only after seeing receive-full set.
// R3: Transmit-empty is set when the transmit bytes are empty, and their word moves inward.
// R4: The host writes the transmit bytes only while transmit-empty is set.
// R5: The host changes the vector only while the host command flag is clear.
// R6: A 16-bit port control register selects bus modes or general-purpose pins.
// R7: Non-multiplexed host mode uses the eight shared pins as data lines 0 to 7.
// R8: Multiplexed host mode uses the eight shared pins as address/data lines 0 to 7.
// R9: Non-multiplexed host mode uses the two extra pins as address lines 0 and 1.
// R10: Multiplexed host mode uses the address-1 pin as address line 8.
// R11: Multiplexed host mode uses the address-0 pin as the address strobe.
// R12: The address strobe polarity is programmable and active low after reset.
// R13: General-purpose mode sets each data pin's direction from the direction register.
// R14: General-purpose mode makes the two extra pins port bits with their own directions.
// R15: During reset all host pins are inputs and their values are ignored.
module host_parallel_port_pins
  import host_port_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic [7:0]  data_pin_in,
  output logic [7:0]       data_pin_out,
  output logic [7:0]       data_pin_oe,
  input  wire logic        pin8_in,
  output logic             pin8_out,
  output logic             pin8_oe,
  input  wire logic        pin9_in,
  output logic             pin9_out,
  output logic             pin9_oe,
  input  wire logic        host_cs_n,
  input  wire logic        host_rd_n,
  input  wire logic        host_wr_n
);

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_READ  = 2'b01,
    HS_WRITE = 2'b11
  } host_state_t;

  // ==========================================================
  // Registers
  logic [CTRL_W-1:0] port_control_reg_r;
  logic [PIN_W-1:0]  pin_direction_reg_r;
  logic [PIN_W-1:0]  gpio_out_r;
  logic [PIN_W-1:0]  gpio_in_r;
  logic [7:0]        rx_byte_high_r;
  logic [7:0]        rx_byte_middle_r;
  logic [7:0]        rx_byte_low_r;
  logic              receive_full_flag_r;
  logic [7:0]        tx_byte_high_r;
  logic [7:0]        tx_byte_middle_r;
  logic [7:0]        tx_byte_low_r;
  logic              tx_loaded_r;
  logic [23:0]       internal_receive_reg_r;
  logic              intrx_valid_r;
  logic              host_command_flag_r;
  logic [VEC_W-1:0]  host_vector_value_r;
  logic [EV_W-1:0]   event_r;
  logic [EV_W-1:0]   mask_r;
  logic [7:0]        latched_addr_r;
  logic [7:0]        host_rdata_r;
  host_state_t       hstate_r;
  host_state_t       hstate_nxt;

  // ==========================================================
  // Pin function decode
  wire host_fn = port_control_reg_r[CTRL_HOST_FN];                    // R6
  wire mux_mode = port_control_reg_r[CTRL_MUX];                       // R6
  wire as_active = pin8_in ^ ~port_control_reg_r[CTRL_AS_POL];        // R12 R11
  wire [1:0] host_addr = mux_mode ? latched_addr_r[1:0]               // R8
                                  : {pin9_in, pin8_in};               // R9
  // Address line 8 must be low in multiplexed mode
  wire addr_hi_ok = ~mux_mode | ~pin9_in;                             // R10
  wire host_sel = host_fn & ~host_cs_n & addr_hi_ok;
  wire host_rd = host_sel & ~host_rd_n;
  wire host_wr = host_sel & ~host_wr_n;
  wire transmit_empty_flag = ~tx_loaded_r;                            // R3

  always_comb begin
    hstate_nxt = hstate_r;
    case (hstate_r)
      HS_IDLE: begin
        if (host_wr) begin
          hstate_nxt = HS_WRITE;
        end else if (host_rd) begin
          hstate_nxt = HS_READ;
        end
      end
      HS_READ: begin
        if (!host_rd) begin
          hstate_nxt = HS_IDLE;
        end
      end
      HS_WRITE: begin
        if (!host_wr) begin
          hstate_nxt = HS_IDLE;
        end
      end
      default: hstate_nxt = HS_IDLE;
    endcase
  end

  wire wr_start = (hstate_r == HS_IDLE) && host_wr;
  wire rd_end = (hstate_r == HS_READ) && !host_rd;
  wire rx_taken = rd_end && (host_addr == HA_LOW) && receive_full_flag_r;
  wire tx_word_done = wr_start && (host_addr == HA_LOW);
  wire hcmd_set = wr_start && (host_addr == HA_STATUS) && data_pin_in[HCMD_BIT];
  // Word moves in once the previous one was read
  wire move_inward = tx_loaded_r && !intrx_valid_r;                   // R3

  // ==========================================================
  // APB decode
  wire apb_acc = psel && penable;
  wire apb_wr = apb_acc && pwrite;
  wire apb_rd = apb_acc && !pwrite;
  wire sel_ctrl = (paddr == OFS_CTRL);
  wire sel_dir = (paddr == OFS_DIR);
  wire sel_gpo = (paddr == OFS_GPO);
  wire sel_gpi = (paddr == OFS_GPI);
  wire sel_rxw = (paddr == OFS_RXWORD);
  wire sel_intrx = (paddr == OFS_INTRX);
  wire sel_stat = (paddr == OFS_STATUS);
  wire sel_mask = (paddr == OFS_MASK);
  wire sel_vec = (paddr == OFS_VECTOR);
  wire sel_any = sel_ctrl | sel_dir | sel_gpo | sel_gpi | sel_rxw | sel_intrx
               | sel_stat | sel_mask | sel_vec;
  // Refilled only once the host took the word
  wire rxw_load = apb_wr && sel_rxw && !receive_full_flag_r;
  wire intrx_read = apb_rd && sel_intrx;
  wire hcmd_clr = apb_wr && sel_stat && pwdata[ST_HCMD];
  wire [EV_W-1:0] ev_clr = (apb_wr && sel_stat) ? pwdata[EV_HCMD:EV_INTRX] : '0;
  wire [EV_W-1:0] ev_set = {hcmd_set, rx_taken, move_inward};

  wire [31:0] status_word = {21'h0, event_r, 4'h0, intrx_valid_r, host_command_flag_r,
                             transmit_empty_flag, receive_full_flag_r};

  assign pready = 1'b1;
  assign pslverr = apb_acc && !sel_any;
  assign irq = |(event_r & mask_r);

  always_comb begin
    prdata = 32'h0;
    if (sel_ctrl) prdata = {16'h0, port_control_reg_r};
    if (sel_dir) prdata = {22'h0, pin_direction_reg_r};
    if (sel_gpo) prdata = {22'h0, gpio_out_r};
    if (sel_gpi) prdata = {22'h0, gpio_in_r};
    if (sel_rxw) prdata = {8'h0, rx_byte_high_r, rx_byte_middle_r, rx_byte_low_r};
    if (sel_intrx) prdata = {8'h0, internal_receive_reg_r};
    if (sel_stat) prdata = status_word;
    if (sel_mask) prdata = {29'h0, mask_r};
    if (sel_vec) prdata = {25'h0, host_vector_value_r};
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      port_control_reg_r  <= CTRL_RST;                                // R12
      pin_direction_reg_r <= PIN_RST;
      gpio_out_r          <= PIN_RST;
      mask_r              <= '0;
    end else if (apb_wr) begin
      if (sel_ctrl) port_control_reg_r <= pwdata[CTRL_W-1:0];        // R6
      if (sel_dir) pin_direction_reg_r <= pwdata[PIN_W-1:0];         // R13 R14
      if (sel_gpo) gpio_out_r <= pwdata[PIN_W-1:0];
      if (sel_mask) mask_r <= pwdata[EV_W-1:0];
    end
  end

  // Pins sampled only out of reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      gpio_in_r <= PIN_RST;                                           // R15
    end else begin
      gpio_in_r <= {pin9_in, pin8_in, data_pin_in};
    end
  end

  // ==========================================================
  // Multiplexed address latch
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      latched_addr_r <= 8'h00;
    end else begin
      if (host_fn && mux_mode && as_active) begin
        latched_addr_r <= data_pin_in;                                // R8 R11
      end
    end
  end

  // ==========================================================
  // Host access state and read data
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hstate_r     <= HS_IDLE;
      host_rdata_r <= 8'h00;
    end else begin
      hstate_r <= hstate_nxt;
      case (host_addr)
        HA_STATUS: host_rdata_r <= {5'h0, host_command_flag_r,
                                    transmit_empty_flag, receive_full_flag_r};
        HA_HIGH: host_rdata_r <= rx_byte_high_r;
        HA_MIDDLE: host_rdata_r <= rx_byte_middle_r;
        default: host_rdata_r <= rx_byte_low_r;
      endcase
    end
  end

  // ==========================================================
  // Receive bytes toward the host
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_byte_high_r      <= 8'h00;
      rx_byte_middle_r    <= 8'h00;
      rx_byte_low_r       <= 8'h00;
      receive_full_flag_r <= 1'b0;
    end else if (rxw_load) begin
      {rx_byte_high_r, rx_byte_middle_r, rx_byte_low_r} <= pwdata[23:0];
      receive_full_flag_r <= 1'b1;                                    // R1
    end else if (rx_taken) begin
      receive_full_flag_r <= 1'b0;                                    // R1 R2
    end
  end

  // ==========================================================
  // Transmit bytes from the host
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_byte_high_r   <= 8'h00;
      tx_byte_middle_r <= 8'h00;
      tx_byte_low_r    <= 8'h00;
      tx_loaded_r      <= 1'b0;
    end else begin
      if (wr_start && host_addr == HA_HIGH) tx_byte_high_r <= data_pin_in;
      if (wr_start && host_addr == HA_MIDDLE) tx_byte_middle_r <= data_pin_in;
      if (tx_word_done) tx_byte_low_r <= data_pin_in;
      if (tx_word_done) begin
        tx_loaded_r <= 1'b1;                                          // R4
      end else if (move_inward) begin
        tx_loaded_r <= 1'b0;                                          // R3
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      internal_receive_reg_r <= 24'h0;
      intrx_valid_r          <= 1'b0;
    end else if (move_inward) begin
      internal_receive_reg_r <= {tx_byte_high_r, tx_byte_middle_r, tx_byte_low_r}; // R3
      intrx_valid_r          <= 1'b1;
    end else if (intrx_read) begin
      intrx_valid_r <= 1'b0;
    end
  end

  // ==========================================================
  // Host command, vector and sticky events
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      host_command_flag_r <= 1'b0;
      host_vector_value_r <= '0;
      event_r             <= '0;
    end else begin
      if (hcmd_set) begin
        host_command_flag_r <= 1'b1;
        host_vector_value_r <= data_pin_in[VEC_W-1:0];                // R5
      end else if (hcmd_clr) begin
        host_command_flag_r <= 1'b0;
      end
      // Set wins over a same-cycle clear
      event_r <= (event_r & ~ev_clr) | ev_set;
    end
  end

  // ==========================================================
  // Pin drivers
  // Drive only after the read strobe was seen for a cycle
  wire host_drive = host_fn && (hstate_r == HS_READ) && host_rd;
  wire [PIN_W-1:0] gpio_oe = host_fn ? '0 : pin_direction_reg_r;      // R13 R14

  assign data_pin_out = host_fn ? host_rdata_r : gpio_out_r[7:0];     // R7 R8
  assign data_pin_oe = rst_n ? (host_drive ? 8'hFF : gpio_oe[7:0]) : 8'h00; // R15 R13 R7
  assign pin8_out = gpio_out_r[8];                                     // R14
  assign pin8_oe = rst_n & gpio_oe[8];                                // R15 R14
  assign pin9_out = gpio_out_r[9];
  assign pin9_oe = rst_n & gpio_oe[9];                                // R15 R14

endmodule : host_parallel_port_pins

// ===== verification/host_port_properties.sv
`timescale 1ns/1ps
module host_port_properties
  import host_port_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  data_pin_out,
  input wire logic [7:0]  data_pin_oe,
  input wire logic        pin8_out,
  input wire logic        pin8_oe,
  input wire logic        pin9_out,
  input wire logic        pin9_oe,
  input wire logic        host_cs_n,
  input wire logic        host_rd_n
);
  // ==========================================================
  // Shadow of the pin configuration
  logic [15:0] ctrl_r;
  logic [9:0]  dir_r;
  logic [9:0]  gpo_r;
  wire         wr_acc = psel && penable && pwrite;
  wire         host_fn = ctrl_r[CTRL_HOST_FN];
  always_ff @(posedge sys_clk) if (!rst_n) ctrl_r <= CTRL_RST;
    else if (wr_acc && paddr == OFS_CTRL) ctrl_r <= pwdata[15:0];
  always_ff @(posedge sys_clk) if (!rst_n) dir_r <= PIN_RST;
    else if (wr_acc && paddr == OFS_DIR) dir_r <= pwdata[9:0];
  always_ff @(posedge sys_clk) if (!rst_n) gpo_r <= PIN_RST;
    else if (wr_acc && paddr == OFS_GPO) gpo_r <= pwdata[9:0];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Properties
  sequence s_rd_held;
    host_fn && !host_cs_n && !host_rd_n ##1 !host_cs_n && !host_rd_n;
  endsequence
  sequence s_rx_loaded;
    wr_acc && paddr == OFS_RXWORD ##3 psel && penable && !pwrite && paddr == OFS_STATUS;
  endsequence
  property p_reset_idle;
    disable iff (1'b0) !rst_n |-> data_pin_oe == 8'h00 && !pin8_oe && !pin9_oe;
  endproperty
  property p_zero_wait; psel && penable |-> pready; endproperty
  property p_unmapped; psel && penable && paddr > OFS_VECTOR |-> pslverr && prdata == '0;
  endproperty
  property p_gpio_pins;
    !host_fn |-> data_pin_oe == dir_r[7:0] && data_pin_out == gpo_r[7:0];
  endproperty
  property p_gpio_extra;
    !host_fn |-> {pin9_oe, pin8_oe, pin9_out, pin8_out} == {dir_r[9:8], gpo_r[9:8]};
  endproperty
  property p_host_extra; host_fn |-> !pin8_oe && !pin9_oe; endproperty
  property p_host_drive; s_rd_held |-> data_pin_oe == 8'hFF; endproperty
  property p_host_release; host_fn && host_rd_n |-> data_pin_oe == 8'h00; endproperty
  property p_rx_full; s_rx_loaded |-> prdata[ST_RX_FULL]; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("pins driven in reset");
  a_zero_wait: assert property (p_zero_wait) else $error("no ready");
  a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
  a_gpio_pins: assert property (p_gpio_pins) else $error("gpio pin mismatch");
  a_gpio_extra: assert property (p_gpio_extra) else $error("gpio bit8/9 mismatch");
  a_host_extra: assert property (p_host_extra) else $error("address pin driven");
  a_host_drive: assert property (p_host_drive) else $error("read data not driven");
  a_host_release: assert property (p_host_release) else $error("bus not released");
  a_rx_full: assert property (p_rx_full) else $error("receive full not set");
endmodule : host_port_properties

// ===== verification/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model
  import host_port_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] dq_in,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic [7:0]      dq,
  output logic            dq_oe,
  output logic            a0,
  output logic            a1
);
  logic mux_mode = 1'b0;
  logic as_high  = 1'b0;
  initial begin
    {cs_n, rd_n, wr_n, dq_oe, a0, a1, dq} = {6'h38, 8'h00};
  end
  task xfer(input logic w, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    if (!mux_mode) begin
      {a1, a0} <= a;
    end else begin
      {a1, a0, dq, dq_oe} <= {1'b0, as_high, 6'h00, a, 1'b1};
      @(posedge sys_clk);
      a0 <= ~as_high;
    end
    cs_n <= 1'b0;
    if (w) {wr_n, dq, dq_oe} <= {1'b0, d, 1'b1};
    else {rd_n, dq_oe} <= 2'b00;
    repeat (2) @(posedge sys_clk);
    q = dq_in;
    {cs_n, rd_n, wr_n, dq_oe} <= 4'hE;
  endtask : xfer
  task poll(input int bit_no, input logic want);
    logic [7:0] s;
    repeat (20) begin
      xfer(1'b0, HA_STATUS, 8'h00, s);
      if (s[bit_no] == want) break;
    end
  endtask : poll
  task send_word(input logic [23:0] w);
    logic [7:0] s;
    poll(ST_TX_EMPTY, 1'b1);
    xfer(1'b1, HA_HIGH, w[23:16], s);
    xfer(1'b1, HA_MIDDLE, w[15:8], s);
    xfer(1'b1, HA_LOW, w[7:0], s);
  endtask : send_word
  task fetch_word(output logic [23:0] w);
    poll(ST_RX_FULL, 1'b1);
    xfer(1'b0, HA_HIGH, 8'h00, w[23:16]);
    xfer(1'b0, HA_MIDDLE, 8'h00, w[15:8]);
    xfer(1'b0, HA_LOW, 8'h00, w[7:0]);
  endtask : fetch_word
  task command(input logic [6:0] v);
    logic [7:0] s;
    poll(ST_HCMD, 1'b0);
    xfer(1'b1, HA_STATUS, {1'b1, v}, s);
  endtask : command
endmodule : host_bus_model

// ===== verification/test_host_parallel_port_pins.sv
`timescale 1ns/1ps
module test_host_parallel_port_pins
  import host_port_pkg::*;
;
  logic        sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0]  paddr = 0, float_r = 8'h5A;
  logic [31:0] pwdata = 0, q;
  logic [23:0] w;
  wire  [31:0] prdata;
  wire  [7:0]  data_pin_out, data_pin_oe, h_dq;
  wire         pready, pslverr, irq, pin8_out, pin8_oe, pin9_out, pin9_oe;
  wire         cs_n, rd_n, wr_n, h_oe, h_a0, h_a1;
  int          err_total = 0, n_checks = 0;
  wire  [7:0]  data_pin_in = (data_pin_oe & data_pin_out)
                           | (~data_pin_oe & (h_oe ? h_dq : float_r));
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) float_r <= float_r + 8'h3B;
  host_parallel_port_pins host_parallel_port_pins_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .data_pin_in(data_pin_in), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
    .pin8_in(pin8_oe ? pin8_out : h_a0), .pin8_out(pin8_out), .pin8_oe(pin8_oe),
    .pin9_in(pin9_oe ? pin9_out : h_a1), .pin9_out(pin9_out), .pin9_oe(pin9_oe),
    .host_cs_n(cs_n), .host_rd_n(rd_n), .host_wr_n(wr_n));
  host_bus_model host_bus_model_inst (.sys_clk(sys_clk), .dq_in(data_pin_in), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .dq(h_dq), .dq_oe(h_oe), .a0(h_a0), .a1(h_a1));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    {q, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb
  task stop_test;
    $display("Checks %0d, errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task t_regs;
    apb(0, OFS_CTRL, 0); check(q, CTRL_RST);
    apb(0, OFS_STATUS, 0); check(q, 32'h2);
    apb(0, 8'h24, 0); check({er, q[30:0]}, 32'h8000_0000);
    apb(1, OFS_CTRL, 32'hABCD_F0F0); apb(0, OFS_CTRL, 0); check(q, 32'hF0F0);
  endtask : t_regs
  task t_gpio;
    apb(1, OFS_CTRL, 0); apb(1, OFS_DIR, 32'h2C3); apb(1, OFS_GPO, 32'h1A5);
    host_bus_model_inst.dq <= 8'h3C;
    host_bus_model_inst.dq_oe <= 1'b1;
    {host_bus_model_inst.a1, host_bus_model_inst.a0} <= 2'b11;
    repeat (3) @(posedge sys_clk);
    check({pin9_oe, pin8_oe, data_pin_oe}, 32'h2C3);
    check({pin9_out, pin8_out, data_pin_out} & 10'h2C3, 32'h081);
    apb(0, OFS_GPI, 0); check(q, 32'h1BD);
    host_bus_model_inst.dq_oe <= 1'b0;
  endtask : t_gpio
  task t_nonmux;
    apb(1, OFS_CTRL, 1); apb(1, OFS_MASK, 1);
    host_bus_model_inst.send_word(24'h123456);
    repeat (2) @(posedge sys_clk); check(irq, 1);
    apb(0, OFS_INTRX, 0); check(q, 32'h123456);
    apb(1, OFS_STATUS, 32'h100); apb(0, OFS_STATUS, 0); check(q & 32'h10F, 32'h2);
    check(irq, 0);
    apb(1, OFS_RXWORD, 32'hA1B2C3); apb(0, OFS_STATUS, 0); check(q[0], 1);
    apb(1, OFS_RXWORD, 32'h777777);
    host_bus_model_inst.fetch_word(w); check(w, 32'hA1B2C3);
    apb(0, OFS_STATUS, 0); check(q & 32'h201, 32'h200);
    check(irq, 0);
  endtask : t_nonmux
  task t_mux;
    host_bus_model_inst.a0 <= 1'b1;
    host_bus_model_inst.mux_mode = 1'b1;
    apb(1, OFS_CTRL, 3); apb(1, OFS_RXWORD, 32'h0F1E2D);
    host_bus_model_inst.fetch_word(w); check(w, 32'h0F1E2D);
    apb(1, OFS_CTRL, 7);
    host_bus_model_inst.a0 <= 1'b0;
    host_bus_model_inst.as_high = 1'b1;
    host_bus_model_inst.send_word(24'h654321);
    apb(0, OFS_INTRX, 0); check(q, 32'h654321);
    host_bus_model_inst.command(7'h35);
    apb(0, OFS_VECTOR, 0); check(q, 32'h35);
    apb(1, OFS_MASK, 4); apb(0, OFS_STATUS, 0); check(q[ST_HCMD], 1);
    check(irq, 1);
    apb(1, OFS_STATUS, 32'h404); apb(0, OFS_STATUS, 0); check(q & 32'h404, 0);
    check(irq, 0);
  endtask : t_mux
  initial begin
    repeat (30000) @(posedge sys_clk);
    err_total++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    check({pin9_oe, pin8_oe, data_pin_oe}, 0);
    rst_n <= 1'b1;
    t_regs();
    t_gpio();
    t_nonmux();
    t_mux();
    stop_test();
  end
endmodule : test_host_parallel_port_pins
bind host_parallel_port_pins host_port_properties host_port_properties_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .pin8_out(pin8_out),
  .pin8_oe(pin8_oe), .pin9_out(pin9_out), .pin9_oe(pin9_oe), .host_cs_n(host_cs_n),
  .host_rd_n(host_rd_n));
